/* File: src/lep_defines.vh */
// constants for the link energy power saver
`ifndef LEP_DEFINES_VH
`define LEP_DEFINES_VH
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define LEP_ADDR_CTRL      12'h000
`define LEP_ADDR_TIMER     12'h004
`define LEP_ADDR_STATUS    12'h008
// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define LEP_CTRL_PDOWN     11
`define LEP_CTRL_AUTOPS    6
`define LEP_CTRL_LTO_HI    7
`define LEP_CTRL_LTO_LO    2
`define LEP_CTRL_ANEG      12
`define LEP_CTRL_RESET     32'h0000_1000
// ---------------------------------------------------------------
// timer register fields
// ---------------------------------------------------------------
`define LEP_TMR_SLEEP_HI   14
`define LEP_TMR_SLEEP_LO   13
`define LEP_TMR_WAKE_HI    12
`define LEP_TMR_WAKE_LO    11
`define LEP_TMR_RESET      32'h0000_2000
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define LEP_CLK_HZ         25000000
`define LEP_MS_CYCLES      (`LEP_CLK_HZ / 1000)
`define LEP_RAND_NEG_MS    80
`define LEP_RAND_POS_MS    60
`define LEP_BURST_MAX      3
// ---------------------------------------------------------------
// state lengths in milliseconds
// ---------------------------------------------------------------
`define LEP_SLEEP_MS_0     16'h03e8
`define LEP_SLEEP_MS_1     16'h07d0
`define LEP_SLEEP_MS_2     16'h0bb8
`define LEP_SLEEP_MS_3     16'h0fa0
`define LEP_WAKE_MS_0      16'h00a0
`define LEP_WAKE_MS_1      16'h0190
`define LEP_WAKE_MS_2      16'h0320
`define LEP_WAKE_MS_3      16'h07d0
`define LEP_LTO_MS_0       16'h03e8
`define LEP_LTO_MS_1       16'h07d0
`define LEP_LTO_MS_2       16'h0bb8
`define LEP_LTO_MS_3       16'h0fa0
`endif

/* File: src/lep_ms_tick.v */
// millisecond tick divider
`default_nettype none
module lep_ms_tick #(
   parameter integer DIV = 25000
) (
   // clock and reset
   input  wire clk,
   input  wire reset_n,
   // control
   input  wire run,
   output reg  tick_r
);
   reg [31:0] cnt_r;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r  <= 32'h0;
         tick_r <= 1'b0;
      end else if (!run) begin
         cnt_r  <= 32'h0;
         tick_r <= 1'b0;
      end else if (cnt_r >= DIV - 1) begin
         cnt_r  <= 32'h0;
         tick_r <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 32'h1;
         tick_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: src/lep_power_saver.v */
// per-port automatic power saving state machine with apb registers
// Behaviour
// RULE_01: software turns the auto power save mode on per port via control bit 6 at any time.
// RULE_02: with the mode on, the machine is in exactly one of low power, wake-up or normal.
// RULE_03: without signal energy the machine cycles low power and wake-up, default two seconds.
// RULE_04: signal energy in low power or wake-up moves the machine to normal.
// RULE_05: link loss in normal returns to low power only after the link time-out expires.
// RULE_06: after reset the machine sits in low power; the code goes to normal on the first clock as bit 6 resets clear.
// RULE_07: forced mode entered in low power cycles until energy, then stays in normal.
// RULE_08: autonegotiation turned off in normal keeps normal after a link drop.
// RULE_09: low power gates major blocks while station management stays alive in both states.
// RULE_10: the sleep interval comes from the two-bit sleep timer field.
// RULE_11: each sleep is offset randomly between minus 80 ms and plus 60 ms.
// RULE_12: wake-up sends at most three fast link pulse bursts alternating pairs a and b.
// RULE_13: the wake-up length comes from the two-bit wake-up timer field.
// RULE_14: after sending wake-up energy the machine returns to low power.
// RULE_15: link time-out length comes from control bits 7 and 2.
// RULE_16: a manual power-down bit acts independently of the automatic machine.
// RULE_17: with the mode off the machine stays in normal with timers idle.
//
// Decided for this implementation: the register offsets and register access over APB.
`default_nettype none
`include "lep_defines.vh"
module lep_power_saver #(
   parameter integer MS_DIV = `LEP_MS_CYCLES
) (
   // clock and reset
   input  wire        clk,
   input  wire        reset_n,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // media and link
   input  wire        signalEnergy,
   input  wire        linkUp,
   // power and wake-up outputs
   output reg         blocksPowerDown,
   output reg         manualPowerDown,
   output reg         flpBurstStart,
   output reg         flpPairB,
   output reg         stationMgmtEnable,
   output reg  [2:0]  powerState
);
   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   localparam [2:0] ST_LOW  = 3'b001;
   localparam [2:0] ST_WAKE = 3'b010;
   localparam [2:0] ST_NORM = 3'b100;
   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   function [15:0] sleepMs;
      input [1:0] sel;
      begin
         case (sel)
            2'b00:   sleepMs = `LEP_SLEEP_MS_0;
            2'b01:   sleepMs = `LEP_SLEEP_MS_1;
            2'b10:   sleepMs = `LEP_SLEEP_MS_2;
            default: sleepMs = `LEP_SLEEP_MS_3;
         endcase
      end
   endfunction
   function [15:0] wakeMs;
      input [1:0] sel;
      begin
         case (sel)
            2'b00:   wakeMs = `LEP_WAKE_MS_0;
            2'b01:   wakeMs = `LEP_WAKE_MS_1;
            2'b10:   wakeMs = `LEP_WAKE_MS_2;
            default: wakeMs = `LEP_WAKE_MS_3;
         endcase
      end
   endfunction
   function [15:0] linkToMs;
      input [1:0] sel;
      begin
         case (sel)
            2'b00:   linkToMs = `LEP_LTO_MS_0;
            2'b01:   linkToMs = `LEP_LTO_MS_1;
            2'b10:   linkToMs = `LEP_LTO_MS_2;
            default: linkToMs = `LEP_LTO_MS_3;
         endcase
      end
   endfunction
   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   reg [2:0] energySync_r;
   reg [2:0] linkSync_r;
   reg       energy_r;
   reg       link_r;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         energySync_r <= 3'b000;
         linkSync_r   <= 3'b000;
         energy_r     <= 1'b0;
         link_r       <= 1'b0;
      end else begin
         energySync_r <= {energySync_r[1:0], signalEnergy};
         linkSync_r   <= {linkSync_r[1:0], linkUp};
         if (energySync_r[1] == energySync_r[2]) begin
            energy_r <= energySync_r[2];
         end
         if (linkSync_r[1] == linkSync_r[2]) begin
            link_r <= linkSync_r[2];
         end
      end
   end
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg  [31:0] ctrl_r;
   reg  [31:0] timer_r;
   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   wire        autoOn  = ctrl_r[`LEP_CTRL_AUTOPS];
   wire        anegOn  = ctrl_r[`LEP_CTRL_ANEG];
   wire        apbAcc  = psel && penable;
   wire [1:0]  sleepSel = timer_r[`LEP_TMR_SLEEP_HI:`LEP_TMR_SLEEP_LO];
   wire [1:0]  wakeSel  = timer_r[`LEP_TMR_WAKE_HI:`LEP_TMR_WAKE_LO];
   wire [1:0]  ltoSel   = {ctrl_r[`LEP_CTRL_LTO_HI], ctrl_r[`LEP_CTRL_LTO_LO]};
   wire        addrOk  = (paddr == `LEP_ADDR_CTRL) || (paddr == `LEP_ADDR_TIMER) ||
                         (paddr == `LEP_ADDR_STATUS);
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r  <= `LEP_CTRL_RESET;
         timer_r <= `LEP_TMR_RESET;
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addrOk;
         if (psel && !penable) begin
            case (paddr)
               `LEP_ADDR_CTRL:   prdata <= ctrl_r;
               `LEP_ADDR_TIMER:  prdata <= timer_r;
               `LEP_ADDR_STATUS: prdata <= {27'h0, link_r, energy_r, state_r};
               default:          prdata <= 32'h0;
            endcase
         end
         if (apbAcc && pready && pwrite && (paddr == `LEP_ADDR_CTRL)) begin
            ctrl_r <= pwdata; // [RULE_01] [RULE_15] [RULE_16]
         end
         if (apbAcc && pready && pwrite && (paddr == `LEP_ADDR_TIMER)) begin
            timer_r <= pwdata; // [RULE_10] [RULE_13]
         end
      end
   end
   // ------------------------------------------------------------
   // random offset generator
   // ------------------------------------------------------------
   reg [15:0] lfsr_r;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lfsr_r <= 16'hace1;
      end else begin
         lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      end
   end
   // offset 0..140 ms shifted by -80 ms
   wire [7:0]  randOfs = (lfsr_r[7:0] > 8'd140) ? (lfsr_r[7:0] - 8'd141) : lfsr_r[7:0];
   wire [15:0] sleepLen = sleepMs(sleepSel) + {8'h0, randOfs} -
                          16'd`LEP_RAND_NEG_MS; // [RULE_11]
   // ------------------------------------------------------------
   // state lengths
   // ------------------------------------------------------------
   reg  [15:0] sleepLen_r;
   wire [15:0] wakeLen = wakeMs(wakeSel);
   wire [15:0] ltoLen  = linkToMs(ltoSel);
   // ------------------------------------------------------------
   // millisecond tick and state timer
   // ------------------------------------------------------------
   wire        msTick;
   reg  [15:0] msCnt_r;
   reg  [1:0]  bursts_r;
   reg         forcedSticky_r;
   wire        timerRun = autoOn && (state_r != ST_NORM || !link_r);
   lep_ms_tick #(
      .DIV     (MS_DIV)
   ) i_lep_ms_tick (
      .clk     (clk),
      .reset_n (reset_n),
      .run     (timerRun), // [RULE_17]
      .tick_r  (msTick)
   );
   wire sleepDone = msTick && (msCnt_r >= sleepLen_r); // [RULE_03] [RULE_10]
   wire wakeDone  = msTick && (msCnt_r >= wakeLen);    // [RULE_13]
   wire ltoDone   = msTick && (msCnt_r >= ltoLen);     // [RULE_15]
   // ------------------------------------------------------------
   // state machine
   // ------------------------------------------------------------
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_LOW: begin
            if (!autoOn) begin
               state_nxt = ST_NORM; // [RULE_17]
            end else if (energy_r) begin
               state_nxt = ST_NORM; // [RULE_04]
            end else if (sleepDone) begin
               state_nxt = ST_WAKE; // [RULE_03]
            end
         end
         ST_WAKE: begin
            if (!autoOn || energy_r) begin
               state_nxt = ST_NORM; // [RULE_04]
            end else if (wakeDone) begin
               state_nxt = ST_LOW; // [RULE_14]
            end
         end
         ST_NORM: begin
            if (autoOn && !link_r && anegOn && !forcedSticky_r && ltoDone) begin
               state_nxt = ST_LOW; // [RULE_05] [RULE_07] [RULE_08]
            end
         end
         default: state_nxt = ST_LOW;
      endcase
   end
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_LOW; // [RULE_06]
      end else begin
         state_r <= state_nxt; // [RULE_02]
      end
   end
   // ------------------------------------------------------------
   // state timer
   // ------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         msCnt_r <= 16'h0;
      end else if (state_nxt != state_r || !timerRun) begin
         msCnt_r <= 16'h0;
      end else if (msTick) begin
         msCnt_r <= msCnt_r + 16'h1;
      end
   end
   // ------------------------------------------------------------
   // sleep length, drawn once per sleep
   // ------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sleepLen_r <= `LEP_SLEEP_MS_1;
      end else if (state_r != ST_LOW) begin
         sleepLen_r <= sleepLen; // [RULE_11]
      end
   end
   // ------------------------------------------------------------
   // forced mode tracking
   // ------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         forcedSticky_r <= 1'b0;
      end else if (anegOn) begin
         forcedSticky_r <= 1'b0;
      end else if (state_r == ST_LOW) begin
         forcedSticky_r <= 1'b1; // [RULE_07]
      end
   end
   // ------------------------------------------------------------
   // fast link pulse bursts
   // ------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bursts_r      <= 2'd0;
         flpBurstStart <= 1'b0;
         flpPairB      <= 1'b0;
      end else begin
         flpBurstStart <= 1'b0;
         if (state_r != ST_WAKE) begin
            bursts_r <= 2'd0;
         end else if (state_nxt == ST_WAKE && msTick &&
                      msCnt_r[5:0] == 6'h0 && bursts_r < `LEP_BURST_MAX) begin
            bursts_r      <= bursts_r + 2'd1; // [RULE_12]
            flpBurstStart <= 1'b1;
            flpPairB      <= bursts_r[0];
         end
      end
   end
   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         blocksPowerDown   <= 1'b0;
         manualPowerDown   <= 1'b0;
         stationMgmtEnable <= 1'b0;
         powerState        <= ST_LOW;
      end else begin
         blocksPowerDown   <= (state_r == ST_LOW); // [RULE_09]
         manualPowerDown   <= ctrl_r[`LEP_CTRL_PDOWN]; // [RULE_16]
         stationMgmtEnable <= 1'b1; // [RULE_09]
         powerState        <= state_r;
      end
   end
endmodule
`default_nettype wire

/* File: verification/lep_power_saver_assertions.sv */
// port checker for the power saver
`default_nettype none
module lep_power_saver_assertions (
   // clock and reset
   input wire logic       clk,
   input wire logic       reset_n,
   // bus
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic       pready,
   // outputs
   input wire logic       flpBurstStart,
   input wire logic       flpPairB,
   input wire logic       manualPowerDown,
   input wire logic       stationMgmtEnable,
   input wire logic [2:0] powerState
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_onehot; $onehot(powerState); endproperty
   a_onehot: assert property (p_onehot) else $error("state not one-hot");
   property p_smi; $past(stationMgmtEnable) |-> stationMgmtEnable; endproperty
   a_smi: assert property (p_smi) else $error("management lost");
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready in access");
   property p_burst; flpBurstStart |-> !powerState[2]; endproperty
   a_burst: assert property (p_burst) else $error("burst in normal");
   property p_pair; $changed(flpPairB) |-> flpBurstStart; endproperty
   a_pair: assert property (p_pair) else $error("pair moved without burst");
   property p_mpd;
      $changed(manualPowerDown) |-> $past(penable && pwrite) || $past(penable && pwrite, 2);
   endproperty
   a_mpd: assert property (p_mpd) else $error("power-down moved alone");
   property p_wake; $rose(powerState[1]) |-> $past(powerState[0]); endproperty
   a_wake: assert property (p_wake) else $error("wake not from low");
   property p_norm; powerState[2] |=> !powerState[1]; endproperty
   a_norm: assert property (p_norm) else $error("normal to wake");
endmodule
bind lep_power_saver lep_power_saver_assertions i_lep_power_saver_assertions (
   .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .flpBurstStart(flpBurstStart), .flpPairB(flpPairB),
   .manualPowerDown(manualPowerDown), .stationMgmtEnable(stationMgmtEnable),
   .powerState(powerState));
`default_nettype wire

/* File: verification/lep_link_partner.sv */
// link partner model driving energy and link status
`default_nettype none
module lep_link_partner (
   // clock
   input  wire logic clk,
   // scenario control
   input  wire logic plugged,
   input  wire logic wantLink,
   // media status
   output var  logic signalEnergy,
   output var  logic linkUp
);
   timeunit 1ns;
   timeprecision 1ps;
   // link trains only after energy is present
   always @(posedge clk) begin
      signalEnergy <= plugged;
      linkUp <= wantLink && signalEnergy;
   end
endmodule
`default_nettype wire

/* File: verification/lep_power_saver_tb_top.sv */
// self-checking testbench for the power saver
`default_nettype none
module lep_power_saver_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, plugged, wantLink;
   logic        signalEnergy, linkUp, bpd, mpd, flp, pairB, smEn;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  powerState;
   int          miscompares, checks_done, sl, wk, nb;
   lep_power_saver #(.MS_DIV(4)) i_lep_power_saver (.clk(clk), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .signalEnergy(signalEnergy),
      .linkUp(linkUp), .blocksPowerDown(bpd), .manualPowerDown(mpd), .flpBurstStart(flp),
      .flpPairB(pairB), .stationMgmtEnable(smEn), .powerState(powerState));
   lep_link_partner i_lep_link_partner (.clk(clk), .plugged(plugged), .wantLink(wantLink),
      .signalEnergy(signalEnergy), .linkUp(linkUp));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rng(input string nm, input int lo, input int hi, input int g);
      checks_done++;
      if (g < lo || g > hi) begin
         miscompares++;
         $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      chk("pslverr", {31'h0, a > 12'h008}, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic waitst(input logic [2:0] s, input int lim, output int n);
      n = 0;
      while (powerState !== s && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk("state reached", {29'h0, s}, {29'h0, powerState});
   endtask
   task automatic meas;
      waitst(3'b010, 20000, sl);
      nb = 0;
      wk = 0;
      while (powerState === 3'b010 && wk < 20000) begin
         @(posedge clk);
         if (flp === 1'b1) begin
            chk("burst pair", {31'h0, nb[0]}, {31'h0, pairB});
            nb++;
         end
         wk++;
      end
   endtask
   task automatic t_cycle;
      apb(1'b1, 12'h000, 32'h0000_1040);
      waitst(3'b001, 5000, sl);
      chk("low gating", 32'h1, {31'h0, bpd});
      meas;
      rng("sleep", 7670, 8260, sl);
      rng("wake", 630, 650, wk);
      rng("bursts", 1, 3, nb);
      apb(1'b1, 12'h004, 32'h0000_0800);
      meas;
      meas;
      rng("sleep sel0", 3670, 4260, sl);
      rng("wake sel1", 1590, 1610, wk);
      rng("bursts long", 1, 3, nb);
      $display("cycle test done");
   endtask
   task automatic t_energy;
      apb(1'b1, 12'h000, 32'h0000_1000);
      waitst(3'b100, 20, sl);
      cyc(5000);
      chk("mode off", 32'h4, {29'h0, powerState});
      apb(1'b1, 12'h000, 32'h0000_10c0);
      waitst(3'b001, 17000, sl);
      plugged <= 1'b1;
      wantLink <= 1'b1;
      waitst(3'b100, 50, sl);
      chk("energy", 32'h4, {29'h0, powerState});
      chk("normal gating", 32'h0, {31'h0, bpd});
      cyc(20);
      plugged <= 1'b0;
      wantLink <= 1'b0;
      waitst(3'b001, 14000, sl);
      rng("link timeout", 11995, 12030, sl);
      $display("energy test done");
   endtask
   task automatic t_forced;
      plugged <= 1'b1;
      wantLink <= 1'b1;
      waitst(3'b100, 50, sl);
      cyc(20);
      apb(1'b1, 12'h000, 32'h0000_0040);
      plugged <= 1'b0;
      wantLink <= 1'b0;
      cyc(6000);
      chk("no fallback", 32'h4, {29'h0, powerState});
      apb(1'b1, 12'h000, 32'h0000_0840);
      cyc(2);
      chk("manual", 32'h1, {31'h0, mpd});
      chk("manual state", 32'h4, {29'h0, powerState});
      $display("forced test done");
   endtask
   task automatic t_forcedlow;
      apb(1'b1, 12'h000, 32'h0000_1040);
      waitst(3'b001, 100, sl);
      apb(1'b1, 12'h000, 32'h0000_0040);
      waitst(3'b010, 5000, sl);
      plugged <= 1'b1;
      wantLink <= 1'b1;
      waitst(3'b100, 50, sl);
      cyc(20);
      plugged <= 1'b0;
      wantLink <= 1'b0;
      cyc(6000);
      chk("forced stays normal", 32'h4, {29'h0, powerState});
      $display("forced low test done");
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #4000000;
      miscompares++;
      test_done;
   end
   initial begin
      {reset_n, psel, penable, pwrite, plugged, wantLink} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      cyc(8);
      chk("reset state", 32'h1, {29'h0, powerState});
      reset_n <= 1'b1;
      cyc(3);
      chk("management", 32'h1, {31'h0, smEn});
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl reset", 32'h0000_1000, rd);
      apb(1'b0, 12'h004, 32'h0);
      chk("timer reset", 32'h0000_2000, rd);
      apb(1'b0, 12'h00c, 32'h0);
      $display("reset test done");
      t_cycle;
      t_energy;
      t_forced;
      t_forcedlow;
      test_done;
   end
endmodule
`default_nettype wire
